//--- design/angle_sensor_fault_monitor.sv
// Purpose: Diagnostic alarm logic and configuration of an angle sensor.
// Assumes: Fault inputs are asynchronous levels; load_start pulses once after power-up.
// Notes: Configuration is copied from the store into working registers at start-up.
// Operation
// - Four-bit alarm: angle, field, storage, any.
// - Load failure latches until power cycle.
// - Field and supply faults recover when cause goes away.
// - Angle fault on all paths, auto-clears.
// - Field alarm only in the alarm register and any bit, on no output path.
// - Supply alarms only through serial output.
// - Three-bit mask keeps alarms out of the any bit and the angle paths.
// - Four-bit field selects output form.
// - Bit enables enhanced serial messages.
// - Bit enables serial frame pause pulse.
// - Two-bit field selects pulse frequency.
`timescale 1ns/10ps
`include "fault_monitor_regs.svh"

module angle_sensor_fault_monitor
    import fault_monitor_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic load_start,
    input wire logic nvm_wr_en,
    input wire logic [`NVM_ADDR_WIDTH-1:0] nvm_wr_addr,
    input wire logic [`NVM_DATA_WIDTH-1:0] nvm_wr_data,
    input wire logic angle_fault_in,
    input wire logic angle_valid_in,
    input wire logic field_fault_in,
    input wire logic analog_supply_fault_in,
    input wire logic digital_supply_fault_in,
    output logic [`ALARM_WIDTH-1:0] diagnostic_alarm_flags,
    output logic config_ready,
    output logic analog_fault_flag,
    output logic pulse_fault_flag,
    output logic serial_angle_fault_flag,
    output logic [11:0] serial_diag_code,
    output logic analog_out_en,
    output logic serial_out_en,
    output logic pulse_out_en,
    output logic enhanced_serial_enable,
    output logic frame_gap_enable,
    output logic [9:0] frame_gap_length,
    output logic [8:0] tick_period_trim,
    output logic [1:0] pulse_frequency_select,
    output logic [13:0] angle_zero_offset,
    output logic rotation_direction,
    output logic [4:0] angle_hysteresis,
    output logic [11:0] seventeen_point_range,
    output logic [11:0] seventeen_point_start,
    output logic [11:0] output_upper_limit,
    output logic [11:0] output_lower_limit
);

    ////////////////////////////////////////////////////////////////////////////////////
    // Input synchronisers.

    localparam int n_in = 5;
    logic [n_in-1:0] raw_in;
    logic [n_in-1:0] sync1_q;
    logic [n_in-1:0] sync2_q;

    assign raw_in = {digital_supply_fault_in, analog_supply_fault_in, field_fault_in,
                     angle_valid_in, angle_fault_in};

    genvar gi;
    generate
        for (gi = 0; gi < n_in; gi++) begin : g_sync
            always_ff @(posedge clk or negedge resetn) begin
                if (!resetn) begin
                    sync1_q[gi] <= 1'b0;
                    sync2_q[gi] <= 1'b0;
                end else begin
                    sync1_q[gi] <= raw_in[gi];
                    sync2_q[gi] <= sync1_q[gi];
                end
            end
        end
    endgenerate

    logic angle_fault_s;
    logic angle_valid_s;
    logic field_fault_s;
    logic asupply_fault_s;
    logic dsupply_fault_s;

    assign angle_fault_s = sync2_q[0];
    assign angle_valid_s = sync2_q[1];
    assign field_fault_s = sync2_q[2];
    assign asupply_fault_s = sync2_q[3];
    assign dsupply_fault_s = sync2_q[4];

    ////////////////////////////////////////////////////////////////////////////////////
    // Start-up copy of the store into working registers.

    load_state_type state_q;
    load_state_type state_d;
    logic [`NVM_ADDR_WIDTH-1:0] addr_q;
    logic [`NVM_ADDR_WIDTH-1:0] addr_d;
    logic rd_pending_q;
    logic [`NVM_DATA_WIDTH-1:0] rd_data;
    logic [`NVM_DATA_WIDTH-1:0] sum_q;
    logic [`NVM_DATA_WIDTH-1:0] sum_d;
    logic [`NVM_DATA_WIDTH-1:0] word_zero_q;
    logic [`NVM_DATA_WIDTH-1:0] word_misc_q;
    logic [`NVM_DATA_WIDTH-1:0] word_gap_q;
    logic [`NVM_DATA_WIDTH-1:0] word_tick_q;
    logic [`NVM_DATA_WIDTH-1:0] word_range_q;
    logic [`NVM_DATA_WIDTH-1:0] word_start_q;
    logic [`NVM_DATA_WIDTH-1:0] word_upper_q;
    logic [`NVM_DATA_WIDTH-1:0] word_lower_q;
    logic nvm_error_q;
    logic data_last;
    logic check_ok;

    nvm_store u_store (
        .clk(clk),
        .wr_en(nvm_wr_en),
        .wr_addr(nvm_wr_addr),
        .wr_data(nvm_wr_data),
        .rd_addr(addr_q),
        .rd_data(rd_data)
    );

    // The check word is the seed plus all data words, so a stuck or erased store fails.
    assign data_last = rd_pending_q && (addr_q == `NVM_LAST_ADDR);
    assign check_ok = (rd_data == sum_q);
    assign sum_d = (rd_pending_q && !data_last) ? sum_q + rd_data : sum_q;

    always_comb begin
        state_d = state_q;
        addr_d = addr_q;
        case (state_q)
            st_idle: begin
                if (load_start) begin
                    state_d = st_load;
                    addr_d = `NVM_ADDR_ZERO;
                end
            end
            st_load: begin
                if (data_last) begin
                    state_d = check_ok ? st_run : st_fail;
                end else if (rd_pending_q) begin
                    addr_d = addr_q + 4'h1;
                end
            end
            st_run: state_d = st_run;
            st_fail: state_d = st_fail;
            default: state_d = st_idle;
        endcase
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_q <= st_idle;
            addr_q <= `NVM_ADDR_ZERO;
            rd_pending_q <= 1'b0;
            sum_q <= `CHECK_SEED;
        end else begin
            state_q <= state_d;
            addr_q <= addr_d;
            rd_pending_q <= (state_d == st_load) && !(rd_pending_q && addr_d != addr_q)
                            && !data_last;
            sum_q <= sum_d;
        end
    end

    // Only a reset, which stands for a power cycle, clears the latched storage fault.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            nvm_error_q <= 1'b0;
        end else if (state_q == st_load && data_last && !check_ok) begin
            nvm_error_q <= 1'b1;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            word_zero_q <= 16'h0000;
            word_misc_q <= 16'h0000;
            word_gap_q <= 16'h0000;
            word_tick_q <= 16'h0000;
            word_range_q <= 16'h0000;
            word_start_q <= 16'h0000;
            word_upper_q <= 16'h0000;
            word_lower_q <= 16'h0000;
        end else if (state_q == st_load && rd_pending_q) begin
            case (addr_q)
                `NVM_ADDR_ZERO: word_zero_q <= rd_data;
                `NVM_ADDR_MISC: word_misc_q <= rd_data;
                `NVM_ADDR_GAP: word_gap_q <= rd_data;
                `NVM_ADDR_TICK: word_tick_q <= rd_data;
                `NVM_ADDR_RANGE: word_range_q <= rd_data;
                `NVM_ADDR_START: word_start_q <= rd_data;
                `NVM_ADDR_UPPER: word_upper_q <= rd_data;
                `NVM_ADDR_LOWER: word_lower_q <= rd_data;
                default: word_zero_q <= word_zero_q;
            endcase
        end
    end

    assign config_ready = (state_q == st_run);

    ////////////////////////////////////////////////////////////////////////////////////
    // Configuration fields.

    logic [2:0] alarm_mask;
    logic [3:0] output_form_select;
    logic [3:0] form_code;

    assign alarm_mask = word_misc_q[`MISC_MASK_LSB +: 3];
    assign rotation_direction = word_misc_q[`MISC_DIR_BIT];
    assign angle_hysteresis = word_misc_q[`MISC_HYS_LSB +: 5];
    assign pulse_frequency_select = word_misc_q[`MISC_FREQ_LSB +: 2];
    assign frame_gap_enable = word_misc_q[`MISC_GAP_EN_BIT];
    assign enhanced_serial_enable = word_misc_q[`MISC_ENH_EN_BIT];
    assign output_form_select = word_zero_q[15:12];
    assign angle_zero_offset = word_zero_q[13:0] & 14'h0fff | {word_misc_q[14:13], 12'h000};
    assign frame_gap_length = word_gap_q[9:0];
    assign tick_period_trim = word_tick_q[8:0];
    assign seventeen_point_range = word_range_q[11:0];
    assign seventeen_point_start = word_start_q[11:0];
    assign output_upper_limit = word_upper_q[11:0];
    assign output_lower_limit = word_lower_q[11:0];

    // Outputs stay off until the configuration has loaded cleanly.
    assign form_code = config_ready ? output_form_select : 4'h0;
    assign analog_out_en = (form_code == form_analog);
    assign serial_out_en = (form_code == form_serial);
    assign pulse_out_en = (form_code == form_pulse);

    ////////////////////////////////////////////////////////////////////////////////////
    // Alarm register.

    logic angle_alarm_q;
    logic field_alarm_q;
    logic [11:0] diag_code_q;
    logic any_error;

    // Angle fault holds until a valid angle appears; a new fault wins over that clear.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            angle_alarm_q <= 1'b0;
        end else if (angle_fault_s) begin
            angle_alarm_q <= 1'b1;
        end else if (angle_valid_s) begin
            angle_alarm_q <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            field_alarm_q <= 1'b0;
        end else begin
            field_alarm_q <= field_fault_s;
        end
    end

    // Supply faults reach only the serial diagnostic code; analog takes priority.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            diag_code_q <= `DIAG_NO_ERROR;
        end else if (asupply_fault_s) begin
            diag_code_q <= `DIAG_ANALOG_SUPPLY;
        end else if (dsupply_fault_s) begin
            diag_code_q <= `DIAG_DIGITAL_SUPPLY;
        end else begin
            diag_code_q <= `DIAG_NO_ERROR;
        end
    end

    assign any_error = |({nvm_error_q, field_alarm_q, angle_alarm_q} & ~alarm_mask);

    assign diagnostic_alarm_flags = {any_error, nvm_error_q, field_alarm_q,
                                     angle_alarm_q};

    assign analog_fault_flag = angle_alarm_q & ~alarm_mask[`ALARM_ANGLE_BIT];
    assign pulse_fault_flag = angle_alarm_q & ~alarm_mask[`ALARM_ANGLE_BIT];
    assign serial_angle_fault_flag = angle_alarm_q & ~alarm_mask[`ALARM_ANGLE_BIT];
    assign serial_diag_code = diag_code_q;

endmodule : angle_sensor_fault_monitor

//--- design/fault_monitor_pkg.sv
// Purpose: Types for the angle sensor fault monitor.
// Assumes: Nothing.
// Notes: Output form codes below are this block's own encoding.
package fault_monitor_pkg;

    typedef enum logic [3:0] {
        form_analog = 4'h1,
        form_serial = 4'h2,
        form_pulse = 4'h4,
        form_off = 4'h8
    } output_form_type;

    typedef enum logic [3:0] {
        st_idle = 4'b0001,
        st_load = 4'b0010,
        st_run = 4'b0100,
        st_fail = 4'b1000
    } load_state_type;

endpackage : fault_monitor_pkg

//--- design/fault_monitor_regs.svh
// Purpose: Constants for the angle sensor fault monitor.
// Assumes: Included by the design files by bare name.
// Notes: Non-volatile word layout and alarm bit positions.
`ifndef FAULT_MONITOR_REGS_SVH
`define FAULT_MONITOR_REGS_SVH

`define ALARM_ANGLE_BIT 0
`define ALARM_FIELD_BIT 1
`define ALARM_NVM_BIT 2
`define ALARM_ANY_BIT 3
`define ALARM_WIDTH 4

`define NVM_WORDS 16
`define NVM_ADDR_WIDTH 4
`define NVM_DATA_WIDTH 16

`define NVM_ADDR_ZERO 4'h0
`define NVM_ADDR_MISC 4'h1
`define NVM_ADDR_GAP 4'h2
`define NVM_ADDR_TICK 4'h3
`define NVM_ADDR_RANGE 4'h4
`define NVM_ADDR_START 4'h5
`define NVM_ADDR_UPPER 4'h6
`define NVM_ADDR_LOWER 4'h7
`define NVM_ADDR_CHECK 4'h8
`define NVM_LAST_ADDR 4'h8

`define MISC_MASK_LSB 0
`define MISC_DIR_BIT 3
`define MISC_HYS_LSB 4
`define MISC_FREQ_LSB 9
`define MISC_GAP_EN_BIT 11
`define MISC_ENH_EN_BIT 12

`define CHECK_SEED 16'h5a5a

`define DIAG_NO_ERROR 12'h800
`define DIAG_ANALOG_SUPPLY 12'h820
`define DIAG_DIGITAL_SUPPLY 12'h840

`endif

//--- design/nvm_store.sv
// Purpose: Small non-volatile word store with registered read data.
// Assumes: One read or write per cycle.
// Notes: Contents are not cleared by reset, like real storage.
`timescale 1ns/10ps
`include "fault_monitor_regs.svh"

module nvm_store (
    input wire logic clk,
    input wire logic wr_en,
    input wire logic [`NVM_ADDR_WIDTH-1:0] wr_addr,
    input wire logic [`NVM_DATA_WIDTH-1:0] wr_data,
    input wire logic [`NVM_ADDR_WIDTH-1:0] rd_addr,
    output logic [`NVM_DATA_WIDTH-1:0] rd_data
);

    logic [`NVM_DATA_WIDTH-1:0] mem [0:`NVM_WORDS-1];

    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end

endmodule : nvm_store

//--- tb/angle_sensor_fault_monitor_properties.sv
// Purpose: Port assertions for the angle sensor fault monitor.
// Assumes: Fault inputs reach the flags within five edges.
// Notes: Mask bits are hidden, so the gated angle paths stand in for them.
`timescale 1ns/10ps
`include "fault_monitor_regs.svh"
module fault_monitor_checker (
    input wire logic clk,
    input wire logic resetn,
    input wire logic load_start,
    input wire logic angle_fault_in,
    input wire logic field_fault_in,
    input wire logic analog_supply_fault_in,
    input wire logic digital_supply_fault_in,
    input wire logic [`ALARM_WIDTH-1:0] diagnostic_alarm_flags,
    input wire logic config_ready,
    input wire logic analog_fault_flag,
    input wire logic pulse_fault_flag,
    input wire logic serial_angle_fault_flag,
    input wire logic [11:0] serial_diag_code,
    input wire logic analog_out_en,
    input wire logic serial_out_en,
    input wire logic pulse_out_en
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    wire [3:0] fl = diagnostic_alarm_flags;
    wire [2:0] en = {analog_out_en, serial_out_en, pulse_out_en};
    ////////////////////////////////////////////////////////////
    a_any_combined: assert property (
        (!fl[3] || (|fl[2:0])) && (!analog_fault_flag || fl[3])) else $error("any bit wrong");
    a_paths_agree: assert property (
        (analog_fault_flag == pulse_fault_flag) && (pulse_fault_flag == serial_angle_fault_flag)
        && (analog_fault_flag -> fl[0])) else $error("angle paths differ");
    a_angle_set: assert property (
        (angle_fault_in && config_ready) [*5] |-> fl[0]) else $error("angle alarm missing");
    a_field_set: assert property (
        (field_fault_in && config_ready) [*5] |-> fl[1]) else $error("field alarm missing");
    a_field_clear: assert property (
        !field_fault_in [*5] |-> !fl[1]) else $error("field alarm stuck");
    a_nvm_sticky: assert property (
        fl[2] |=> fl[2]) else $error("storage error dropped");
    a_ready_excl: assert property (
        !(config_ready && fl[2])) else $error("ready with storage error");
    a_supply_code: assert property (
        analog_supply_fault_in [*5] |-> serial_diag_code == 12'h820) else $error("code not 820");
    a_supply_clear: assert property (
        !(analog_supply_fault_in || digital_supply_fault_in) [*5] |-> serial_diag_code == 12'h800)
        else $error("code not 800");
    a_form_gate: assert property (
        $onehot0(en) && (config_ready || en == 3'h0)) else $error("bad output enables");
    a_load_done: assert property (
        load_start && !config_ready && !fl[2] |-> ##[1:40] (config_ready || fl[2]))
        else $error("load never ended");
    c_load_ok: cover property ($rose(config_ready));
    c_load_fail: cover property ($rose(fl[2]));
    c_digital: cover property (serial_diag_code == 12'h840);
endmodule : fault_monitor_checker

bind angle_sensor_fault_monitor fault_monitor_checker chk_u (.clk, .resetn, .load_start,
    .angle_fault_in, .field_fault_in, .analog_supply_fault_in, .digital_supply_fault_in,
    .diagnostic_alarm_flags, .config_ready, .analog_fault_flag, .pulse_fault_flag,
    .serial_angle_fault_flag, .serial_diag_code, .analog_out_en, .serial_out_en, .pulse_out_en);

//--- tb/angle_sensor_fault_monitor_tb.sv
// Purpose: Self-checking bench for the angle sensor fault monitor.
// Assumes: The programmer model fills the store before each reset that do_load applies.
// Notes: Words are random from a fixed seed; form codes and two masks are forced.
`timescale 1ns/10ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin fails++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, a, e); end end
module angle_sensor_fault_monitor_tb;
    import fault_monitor_pkg::*;
    logic clk, resetn, load_start, nvm_wr_en, angle_fault_in, angle_valid_in, field_fault_in;
    logic analog_supply_fault_in, digital_supply_fault_in, config_ready, analog_fault_flag;
    logic pulse_fault_flag, serial_angle_fault_flag, analog_out_en, serial_out_en, pulse_out_en;
    logic enhanced_serial_enable, frame_gap_enable, rotation_direction;
    logic [3:0] nvm_wr_addr, diagnostic_alarm_flags;
    logic [11:0] serial_diag_code, seventeen_point_range, seventeen_point_start;
    logic [11:0] output_upper_limit, output_lower_limit;
    logic [15:0] nvm_wr_data, w [8];
    logic [9:0] frame_gap_length;
    logic [8:0] tick_period_trim;
    logic [1:0] pulse_frequency_select;
    logic [13:0] angle_zero_offset;
    logic [4:0] angle_hysteresis;
    logic [2:0] m;
    logic [31:0] rng = 32'h52;
    int fails = 0;
    int total_checks = 0;
    int cycles = 0;
    angle_sensor_fault_monitor dut_u (.clk, .resetn, .load_start, .nvm_wr_en, .nvm_wr_addr,
        .nvm_wr_data, .angle_fault_in, .angle_valid_in, .field_fault_in, .analog_supply_fault_in,
        .digital_supply_fault_in, .diagnostic_alarm_flags, .config_ready, .analog_fault_flag,
        .pulse_fault_flag, .serial_angle_fault_flag, .serial_diag_code, .analog_out_en,
        .serial_out_en, .pulse_out_en, .enhanced_serial_enable, .frame_gap_enable,
        .frame_gap_length, .tick_period_trim, .pulse_frequency_select, .angle_zero_offset,
        .rotation_direction, .angle_hysteresis, .seventeen_point_range, .seventeen_point_start,
        .output_upper_limit, .output_lower_limit);
    nvm_programmer prog_u (.clk, .nvm_wr_en, .nvm_wr_addr, .nvm_wr_data);
    ////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    function automatic logic [15:0] rnd16();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng[15:0];
    endfunction : rnd16
    function automatic logic [2:0] exp_en(input logic [3:0] f);
        return {f == form_analog, f == form_serial, f == form_pulse};
    endfunction : exp_en
    // Five cycles covers the two-stage sync plus the flag register.
    task automatic apply(input logic [4:0] v);
        {angle_fault_in, angle_valid_in, field_fault_in, analog_supply_fault_in,
            digital_supply_fault_in} = v;
        #100;
    endtask : apply
    task automatic do_load(input logic bad);
        int n;
        prog_u.write_words(w, bad);
        resetn = 1'b0;
        #120;
        resetn = 1'b1;
        #20;
        load_start = 1'b1;
        #20;
        load_start = 1'b0;
        for (n = 0; n < 60 && config_ready !== 1'b1 && diagnostic_alarm_flags[2] !== 1'b1;
             n++) #20;
    endtask : do_load
    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : stop_test
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            fails++;
            stop_test();
        end
    end
    initial begin
        resetn = 1'b0;
        load_start = 1'b0;
        {angle_fault_in, angle_valid_in, field_fault_in, analog_supply_fault_in,
            digital_supply_fault_in} = 5'h0;
        #111;
        resetn = 1'b1;
        for (int i = 0; i < 4; i++) begin
            foreach (w[k]) w[k] = rnd16();
            w[0][15:12] = 4'h1 << i;
            if (i < 2) w[1][2:0] = {3{i[0]}};
            m = w[1][2:0];
            do_load(1'b0);
            `CHK({config_ready, diagnostic_alarm_flags}, 5'h10)
            `CHK({analog_out_en, serial_out_en, pulse_out_en}, exp_en(w[0][15:12]))
            `CHK({enhanced_serial_enable, frame_gap_enable}, w[1][12:11])
            `CHK(pulse_frequency_select, w[1][10:9])
            `CHK({angle_zero_offset, rotation_direction, angle_hysteresis},
                {w[1][14:13], w[0][11:0], w[1][3], w[1][8:4]})
            `CHK({frame_gap_length, tick_period_trim}, {w[2][9:0], w[3][8:0]})
            `CHK({seventeen_point_range, seventeen_point_start}, {w[4][11:0], w[5][11:0]})
            `CHK({output_upper_limit, output_lower_limit}, {w[6][11:0], w[7][11:0]})
            apply(5'b11000);
            `CHK(diagnostic_alarm_flags, {~m[0], 3'b001})
            `CHK({analog_fault_flag, pulse_fault_flag, serial_angle_fault_flag},
                {3{~m[0]}})
            apply(5'b01111);
            `CHK(diagnostic_alarm_flags, {~m[1], 3'b010})
            `CHK({analog_fault_flag, serial_diag_code}, {1'b0, 12'h820})
            apply(5'b01001);
            `CHK({diagnostic_alarm_flags, serial_diag_code}, {4'h0, 12'h840})
            apply(5'b01000);
            `CHK(serial_diag_code, 12'h800)
            $display("test form %0d done", i);
        end
        // A pulse form in the store shows that a failed load keeps the output off.
        w[0][15:12] = 4'h4;
        do_load(1'b1);
        `CHK({config_ready, diagnostic_alarm_flags[2], pulse_out_en}, 3'b010)
        load_start = 1'b1;
        apply(5'b01000);
        load_start = 1'b0;
        `CHK({config_ready, diagnostic_alarm_flags[2]}, 2'b01)
        $display("test bad load done");
        do_load(1'b0);
        `CHK({config_ready, diagnostic_alarm_flags[2], pulse_out_en}, 3'b101)
        $display("test recovery done");
        stop_test();
    end
endmodule : angle_sensor_fault_monitor_tb

//--- tb/nvm_programmer.sv
// Purpose: Programmer model that writes configuration words into the store.
// Assumes: One word a cycle, launched just after a rising edge.
// Notes: Released lines show an inverted pattern so a stale value never passes.
`timescale 1ns/10ps
module nvm_programmer (
    input wire logic clk,
    output logic nvm_wr_en,
    output logic [3:0] nvm_wr_addr,
    output logic [15:0] nvm_wr_data
);
    initial begin
        nvm_wr_en = 1'b0;
        nvm_wr_addr = 4'h0;
        nvm_wr_data = 16'h0;
    end
    ////////////////////////////////////////////////////////////
    task automatic write_words(input logic [15:0] w [8], input logic bad);
        logic [15:0] sum;
        sum = 16'h5a5a;
        for (int k = 0; k < 9; k++) begin
            @(posedge clk);
            #1;
            nvm_wr_en = 1'b1;
            nvm_wr_addr = 4'(k);
            nvm_wr_data = (k < 8) ? w[k] : sum ^ {15'h0, bad};
            if (k < 8) sum = sum + w[k];
        end
        @(posedge clk);
        #1;
        nvm_wr_en = 1'b0;
        nvm_wr_addr = ~nvm_wr_addr;
        nvm_wr_data = ~nvm_wr_data;
    endtask : write_words
endmodule : nvm_programmer
